// File: rtl/olpf_params.svh
// Constants for the offload low-pass filter block
`ifndef OLPF_PARAMS_SVH
`define OLPF_PARAMS_SVH
`define OLPF_WORD_W 18
`define OLPF_FRAC_W 17
`define OLPF_BETA_RST 18'h1F000
`define OLPF_PERIOD_W 16
`define OLPF_PERIOD_RST 16'h0064
`define OLPF_FIFO_DEPTH 8
`endif

// File: rtl/olpf_pkg.sv
// Types shared by the offload low-pass filter block
`include "olpf_params.svh"
package olpf_pkg;
    // One telemetry sample with its variable index
    typedef struct packed {
        logic [2:0] var_idx;
        logic [`OLPF_WORD_W-1:0] value;
    } olpf_sample_t;
    // Frame-synchronous parameter set
    typedef struct packed {
        logic [`OLPF_WORD_W-1:0] beta;
        logic [`OLPF_PERIOD_W-1:0] period;
    } olpf_param_t;
    typedef enum logic [1:0] {
        OLPF_IDLE = 2'b00,
        OLPF_CALC = 2'b01,
        OLPF_SEND = 2'b10
    } olpf_state_t;
endpackage

// File: rtl/olpf_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module olpf_fifo #(
    parameter int WIDTH = 21,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o = mem_q[rd_q];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    ////////////////////////////////////////////////////////////////
    // Storage, written only on an accepted push
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    // Pointers and fill count
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    a_fifo_no_overflow: assert property (@(posedge clk_i) disable iff (rst_i)
        cnt_q <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule

// File: rtl/olpf_top.sv
// Per-frame one-pole low-pass filter bank for offload telemetry
`timescale 1ns/1ps
`include "olpf_params.svh"
module olpf_top #(
    parameter int NVAR = 8,
    parameter int W = `OLPF_WORD_W,
    parameter int FIFO_DEPTH = `OLPF_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Frame timing
    input wire logic frame_start_i,
    // Telemetry samples from the compute array
    input wire logic smp_valid_i,
    input wire olpf_pkg::olpf_sample_t smp_i,
    // Telemetry pass-through to disk store
    output logic tlm_valid_o,
    output olpf_pkg::olpf_sample_t tlm_o,
    // Parameter load from supervisory side
    input wire logic prm_load_i,
    input wire olpf_pkg::olpf_param_t prm_i,
    // Offload request and output
    input wire logic off_req_i,
    output logic off_valid_o,
    input wire logic off_ready_i,
    output olpf_pkg::olpf_sample_t off_o,
    output logic busy_o
);
    localparam int FW = $bits(olpf_pkg::olpf_sample_t);
    localparam int IW = $clog2(NVAR);

    olpf_pkg::olpf_param_t pend_q;
    olpf_pkg::olpf_param_t act_q;
    logic pend_vld_q;
    logic [W-1:0] state_q [NVAR];
    olpf_pkg::olpf_sample_t hold_q;
    logic hold_vld_q;
    logic [`OLPF_PERIOD_W-1:0] frm_cnt_q;
    logic dump_pend_q;
    olpf_pkg::olpf_state_t st_q;
    logic [IW-1:0] idx_q;
    logic fifo_ready;
    logic busy_d;

    ////////////////////////////////////////////////////////////////
    // Pass the telemetry straight on; filtering never stalls it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tlm_valid_o <= 1'b0;
            tlm_o <= '0;
        end else begin
            tlm_valid_o <= smp_valid_i;
            tlm_o <= smp_i;
        end
    end

    // Capture the sample for the filter pipeline
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_vld_q <= 1'b0;
            hold_q <= '0;
        end else begin
            hold_vld_q <= smp_valid_i;
            hold_q <= smp_i;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Parameters wait in a shadow copy until the frame boundary
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_q <= '0;
            pend_vld_q <= 1'b0;
            act_q.beta <= `OLPF_BETA_RST;
            act_q.period <= `OLPF_PERIOD_RST;
        end else begin
            if (prm_load_i) begin
                pend_q <= prm_i;
                pend_vld_q <= 1'b1;
            end else if (frame_start_i) begin
                pend_vld_q <= 1'b0;
            end
            if (frame_start_i && pend_vld_q) begin
                act_q <= pend_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Filter state, one update per variable completion
    // Written as old + (1-beta)*(x - old): one multiply, and the
    // difference is kept at W+1 bits so no range is lost.
    generate
        for (genvar v = 0; v < NVAR; v++) begin : g_var
            logic signed [W:0] diff;
            logic signed [2*W+1:0] prod;
            logic [W-1:0] gain;
            assign gain = (W)'((1 << `OLPF_FRAC_W)) - act_q.beta;
            assign diff = $signed({hold_q.value[W-1], hold_q.value})
                - $signed({state_q[v][W-1], state_q[v]});
            assign prod = diff * $signed({1'b0, gain});
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    state_q[v] <= '0;
                end else if (hold_vld_q && hold_q.var_idx == 3'(v)) begin
                    state_q[v] <= state_q[v]
                        + W'(prod >>> `OLPF_FRAC_W);
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////
    // Periodic offload timer, in frames, far slower than frames
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            frm_cnt_q <= '0;
            dump_pend_q <= 1'b0;
        end else begin
            if (frame_start_i) begin
                if (frm_cnt_q + 1'b1 >= act_q.period) begin
                    frm_cnt_q <= '0;
                end else begin
                    frm_cnt_q <= frm_cnt_q + 1'b1;
                end
            end
            if ((frame_start_i && frm_cnt_q + 1'b1 >= act_q.period)
                || off_req_i) begin
                dump_pend_q <= 1'b1;
            end else if (st_q == olpf_pkg::OLPF_IDLE) begin
                // Cleared as the walk starts, so a request that lands
                // mid-walk survives and earns one more walk
                dump_pend_q <= 1'b0;
            end
        end
    end

    // Dump sequencer walks the bank into the FIFO
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= olpf_pkg::OLPF_IDLE;
            idx_q <= '0;
        end else begin
            case (st_q)
                olpf_pkg::OLPF_IDLE: begin
                    if (dump_pend_q) begin
                        st_q <= olpf_pkg::OLPF_SEND;
                        idx_q <= '0;
                    end
                end
                olpf_pkg::OLPF_SEND: begin
                    if (fifo_ready) begin
                        if (idx_q == IW'(NVAR-1)) begin
                            st_q <= olpf_pkg::OLPF_IDLE;
                        end else begin
                            idx_q <= idx_q + 1'b1;
                        end
                    end
                end
                default: begin
                    st_q <= olpf_pkg::OLPF_IDLE;
                end
            endcase
        end
    end

    assign busy_d = (st_q != olpf_pkg::OLPF_IDLE);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_o <= 1'b0;
        end else begin
            busy_o <= busy_d;
        end
    end

    // Offload words buffered so the supervisor may stall
    olpf_fifo #(
        .WIDTH(FW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(st_q == olpf_pkg::OLPF_SEND),
        .in_ready_o(fifo_ready),
        .in_data_i({3'(idx_q), state_q[idx_q]}),
        .out_valid_o(off_valid_o),
        .out_ready_i(off_ready_i),
        .out_data_o(off_o)
    );

    ////////////////////////////////////////////////////////////////
    a_frame_param_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !frame_start_i |=> $stable(act_q))
        else $error("parameters changed off a frame boundary");
    a_tlm_pass_thru: assert property (@(posedge clk_i) disable iff (rst_i)
        smp_valid_i |=> tlm_valid_o && tlm_o == $past(smp_i))
        else $error("telemetry not passed on next cycle");
    a_state_idle_var: assert property (@(posedge clk_i) disable iff (rst_i)
        !hold_vld_q |=> $stable(state_q[0]))
        else $error("filter state moved with no sample");
    a_state_step: assert property (@(posedge clk_i) disable iff (rst_i)
        hold_vld_q && hold_q.var_idx == 3'h0 && act_q.beta == 18'h00000
        |=> state_q[0] == $past(hold_q.value))
        else $error("zero coefficient must load sample");
    a_req_dumps: assert property (@(posedge clk_i) disable iff (rst_i)
        off_req_i && st_q == olpf_pkg::OLPF_IDLE
        |=> ##1 st_q == olpf_pkg::OLPF_SEND)
        else $error("request did not start offload");
endmodule

// File: tb/olpf_sup_model.sv
// Supervisory-side consumer model for offload words
`timescale 1ns/1ps
module olpf_sup_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Offload stream
    input wire logic off_valid_i,
    input wire olpf_pkg::olpf_sample_t off_i,
    output logic off_ready_o,
    // Bench control
    input wire logic stall_i
);
    olpf_pkg::olpf_sample_t words_q [0:15];
    int count_q;
    // Host paces the slow rate; stall emulates a busy host
    assign off_ready_o = !stall_i;
    // Keep the last 16 accepted words, indexed by count_q, for later routing
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_q <= 0;
        end else if (off_valid_i && off_ready_o) begin
            words_q[count_q[3:0]] <= off_i;
            count_q <= count_q + 1;
        end
    end
endmodule

// File: tb/testbench.sv
// Self-checking bench for the offload low-pass filter
`timescale 1ns/1ps
`define CHK(a, b) chk_val((a) === (b), 64'(a), 64'(b))
module testbench;
    logic clk_i = 0, rst_i = 1, frame_start_i = 0, smp_valid_i = 0;
    logic prm_load_i = 0, off_req_i = 0, stall = 0;
    logic tlm_valid_o, off_valid_o, off_ready_i, busy_o;
    olpf_pkg::olpf_sample_t smp_i = '0, tlm_o, off_o;
    olpf_pkg::olpf_param_t prm_i = '0;
    logic signed [17:0] exp_q [0:7] = '{default: '0};
    logic [17:0] beta = 18'h1F000;
    int fail_count = 0, total_checks = 0, b;
    olpf_top olpf_top_i (.clk_i(clk_i), .rst_i(rst_i),
        .frame_start_i(frame_start_i), .smp_valid_i(smp_valid_i),
        .smp_i(smp_i), .tlm_valid_o(tlm_valid_o), .tlm_o(tlm_o),
        .prm_load_i(prm_load_i), .prm_i(prm_i), .off_req_i(off_req_i),
        .off_valid_o(off_valid_o), .off_ready_i(off_ready_i),
        .off_o(off_o), .busy_o(busy_o));
    olpf_sup_model olpf_sup_model_i (.clk_i(clk_i), .rst_i(rst_i),
        .off_valid_i(off_valid_o), .off_i(off_o),
        .off_ready_o(off_ready_i), .stall_i(stall));
    initial forever #5 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////
    task chk_val(input bit ok, input logic [63:0] a, e);
        total_checks++;
        if (!ok) begin
            fail_count++;
            $display("unexpected at %0t: got %0h want %0h", $time, a, e);
        end
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Own reference arithmetic, floor shift like the datapath
    function automatic logic [17:0] filt(input logic signed [17:0] o,
            input logic signed [17:0] x, input logic [17:0] c);
        longint d;
        d = ((longint'(x) - longint'(o)) * (131072 - longint'(c))) >>> 17;
        return 18'(longint'(o) + d);
    endfunction
    // Callers sit just after an edge, so pushes run back to back
    task push(input logic [2:0] i, input logic [17:0] v);
        smp_valid_i <= 1'b1;
        smp_i <= {i, v};
        @(posedge clk_i);
        #1;
        `CHK({tlm_valid_o, tlm_o}, {1'b1, smp_i});
        exp_q[i] = filt(exp_q[i], v, beta);
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task frame;
        frame_start_i <= 1'b1;
        tick(1);
        frame_start_i <= 1'b0;
    endtask
    task dump(input int base, input bit req);
        int k;
        if (req) begin
            off_req_i <= 1'b1;
            tick(1);
            off_req_i <= 1'b0;
        end
        for (k = 0; k < 300 && olpf_sup_model_i.count_q < base + 8; k++)
            @(posedge clk_i);
        if (k == 300) begin
            fail_count++;
            print_verdict();
        end
        #1;
        for (k = 0; k < 8; k++)
            `CHK(olpf_sup_model_i.words_q[(base + k) % 16], {k[2:0], exp_q[k]});
    endtask
    ////////////////////////////////////////////////////////////////
    // Two signed samples, then a dump against a stalled host
    task t_filter;
        push(3'h3, 18'h10000);
        push(3'h5, 18'h30000);
        smp_valid_i <= 1'b0;
        tick(1);
        `CHK(tlm_valid_o, 1'b0);
        b = olpf_sup_model_i.count_q;
        stall <= 1'b1;
        off_req_i <= 1'b1;
        tick(1);
        off_req_i <= 1'b0;
        tick(4);
        `CHK({busy_o, off_valid_o}, 2'b11);
        tick(20);
        `CHK({off_o, olpf_sup_model_i.count_q}, {21'h0, b});
        stall <= 1'b0;
        dump(b, 1'b0);
        $display("test filter done");
    endtask
    // Coefficient load must wait for the frame boundary
    task t_param;
        prm_i <= {18'h10000, 16'h0002};
        prm_load_i <= 1'b1;
        tick(1);
        prm_load_i <= 1'b0;
        push(3'h1, 18'h10000);
        smp_valid_i <= 1'b0;
        frame();
        beta = 18'h10000;
        push(3'h1, 18'h10000);
        smp_valid_i <= 1'b0;
        tick(3);
        b = olpf_sup_model_i.count_q;
        dump(b, 1'b1);
        `CHK(exp_q[1], 18'h08400);
        $display("test param done");
    endtask
    // Period of two frames must dump without a request
    task t_period;
        int i;
        b = olpf_sup_model_i.count_q;
        for (i = 0; i < 6; i++) begin
            frame();
            tick(20);
        end
        dump(b, 1'b0);
        `CHK(olpf_sup_model_i.count_q, b + 24);
        $display("test period done");
    endtask
    // Zero coefficient passes the sample straight into the state
    task t_zero;
        prm_i <= {18'h00000, 16'h0100};
        prm_load_i <= 1'b1;
        tick(1);
        prm_load_i <= 1'b0;
        frame();
        beta = 18'h00000;
        tick(20);
        push(3'h0, 18'h12345);
        smp_valid_i <= 1'b0;
        tick(2);
        b = olpf_sup_model_i.count_q;
        dump(b, 1'b1);
        `CHK(exp_q[0], 18'h12345);
        $display("test zero done");
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        tick(20);
        rst_i <= 1'b0;
        tick(1);
        `CHK({tlm_valid_o, off_valid_o, busy_o}, 3'b000);
        `CHK($bits(smp_i.value), 18);
        $display("test reset done");
        t_filter();
        t_param();
        t_period();
        t_zero();
        print_verdict();
    end
endmodule
